// ===== hdl/tpg_core.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_core
  import tpg_pkg::*;
#(
  parameter int CLK_HZ = 10_000_000
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_pulse_output_pin,
  output logic o_pulse_output_pin_oe,
  output logic o_irq
);

  logic [7:0] mode_r;
  logic [7:0] modulo_high_reg_r;
  logic [7:0] modulo_low_reg_r;
  logic [TPG_LATCH_W-1:0] latch_r;
  logic [TPG_PWM_W-1:0] cnt_r;
  logic [TPG_PSC_W-1:0] tcnt_r;
  logic tff_r;
  logic pwm_r;
  logic [TPG_NEV-1:0] stat_r;
  logic [TPG_NEV-1:0] mask_r;
  logic [7:0] rdata_r;
  logic wr_mode;
  logic start;
  logic run;
  logic timer_mode;
  logic psc_tick;
  logic interval_hit;
  logic pwm_period;
  logic [TPG_NEV-1:0] ev;

  function automatic logic hit(input logic [2:0] a);
    hit = i_wr && (i_addr == a);
  endfunction : hit

  assign wr_mode = hit(TPG_ADDR_MODE);
  assign start = wr_mode && i_wdata[TPG_B_RUN] && !mode_r[TPG_B_RUN];
  assign run = mode_r[TPG_B_RUN];
  assign timer_mode = mode_r[TPG_B_MODE];

  // Mode register, bits 2 and 6 stay zero
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mode_r <= TPG_MODE_RST;
    else if (wr_mode)
      mode_r <= i_wdata & TPG_MODE_WMASK;
    else if (hit(TPG_ADDR_BITOP))
      mode_r[TPG_B_RELOAD] <= i_wdata[TPG_BITOP_VAL];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      modulo_high_reg_r <= TPG_MODULO_HIGH_REG_RST;
      modulo_low_reg_r <= TPG_MODULO_LOW_REG_RST;
    end
    else
    begin
      if (hit(TPG_ADDR_MODULO_HIGH_REG))
        modulo_high_reg_r <= i_wdata;
      if (hit(TPG_ADDR_MODULO_LOW_REG))
        modulo_low_reg_r <= i_wdata;
    end
  end

  // Latch only tracks while reload is enabled, so MODULO_HIGH_REG/MODULO_LOW_REG edits reach the PWM atomically; timer mode reads both registers directly
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      latch_r <= '0;
    else if (mode_r[TPG_B_RELOAD])
      latch_r <= {modulo_high_reg_r, modulo_low_reg_r[7:TPG_PSC_LO]};
  end

  // Free counter: prescaler in timer mode, PWM phase in PWM mode
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_r <= '0;
    else if (start)
      cnt_r <= '0;
    else if (run)
      cnt_r <= cnt_r + 1'b1;
  end

  // Taps 16/32/64/128/256 chosen by one-hot MODULO_LOW_REG bits 6..2
  logic [4:0] tap_hit;
  for (genvar g = 0; g < 5; g++)
  begin : g_tap
    assign tap_hit[g] = modulo_low_reg_r[6-g] && (&cnt_r[3+g:0]);
  end
  assign psc_tick = |tap_hit;

  assign interval_hit = run && timer_mode && psc_tick && (tcnt_r == modulo_high_reg_r);
  assign pwm_period = run && !timer_mode && (cnt_r == '1);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      tcnt_r <= '0;
    else if (start || interval_hit)
      tcnt_r <= '0;
    else if (run && timer_mode && psc_tick)
      tcnt_r <= tcnt_r + 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      tff_r <= 1'b0;
    else if (start)
      tff_r <= 1'b0;
    else if (interval_hit)
      tff_r <= ~tff_r;
  end

  // Active-low PWM: base period 2^10 low for four clocks per unit of the high 8 bits of the latch,
  // plus two extra clocks in those of 32 sub-periods picked by the low 6 bits.
  // Spreading the fine bits keeps the filter time constant short.
  logic [TPG_BASE_W-1:0] base_ph;
  logic [4:0] sub_ph;
  logic [1:0] extra;
  logic [4:0] dith;
  logic [TPG_BASE_W:0] low_len;
  assign base_ph = cnt_r[TPG_BASE_W-1:0];
  assign sub_ph = cnt_r[TPG_PWM_W-1:TPG_BASE_W];
  // Bits 4..0 pick disjoint sub-periods; bit 5 adds to every sub-period
  for (genvar g = 0; g < 5; g++)
  begin : g_dith
    assign dith[g] = latch_r[g] && ((sub_ph & 5'((32'h2 << (4 - g)) - 32'h1)) == 5'(32'h1 << (4 - g)));
  end
  assign extra = {1'b0, latch_r[5]} + {1'b0, |dith};
  // Two clocks per fine step: a full frame stays low for twice the latch value
  assign low_len = {1'b0, latch_r[13:6], 2'b00} + {8'h00, extra, 1'b0};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pwm_r <= 1'b1;
    else if (!run || timer_mode)
      pwm_r <= 1'b1;
    else
      pwm_r <= !({1'b0, base_ph} < low_len);
  end

  logic pulse_sig;
  assign pulse_sig = timer_mode ? tff_r : pwm_r;

  // Pin: level from mode LEVEL bit or pulse, floated when drive is off
  always_comb
  begin
    o_pulse_output_pin_oe = mode_r[TPG_B_DRIVE];
    if (mode_r[TPG_B_OSEL])
      o_pulse_output_pin = pulse_sig;
    else
      o_pulse_output_pin = mode_r[TPG_B_LEVEL];
  end

  // Interrupt status, set wins over write-one-to-clear
  assign ev[TPG_ST_IRQ] = interval_hit || pwm_period;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      stat_r <= '0;
    else if (hit(TPG_ADDR_STAT))
      stat_r <= (stat_r & ~i_wdata[TPG_NEV-1:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mask_r <= '0;
    else if (hit(TPG_ADDR_MASK))
      mask_r <= i_wdata[TPG_NEV-1:0];
  end

  assign o_irq = |(stat_r & mask_r);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_r <= '0;
    else if (!i_rd)
      rdata_r <= '0;
    else if (i_addr == TPG_ADDR_MODE)
      rdata_r <= mode_r;
    else if (i_addr == TPG_ADDR_MODULO_HIGH_REG)
      rdata_r <= modulo_high_reg_r;
    else if (i_addr == TPG_ADDR_MODULO_LOW_REG)
      rdata_r <= {modulo_low_reg_r[7:TPG_PSC_LO], 2'b00};
    else if (i_addr == TPG_ADDR_STAT)
      rdata_r <= {{(8-TPG_NEV){1'b0}}, stat_r};
    else if (i_addr == TPG_ADDR_MASK)
      rdata_r <= {{(8-TPG_NEV){1'b0}}, mask_r};
    else
      rdata_r <= '0;
  end
  assign o_rdata = rdata_r;

  a_reset_clears: assert property (@(posedge i_clk) $rose(i_rstn) |-> mode_r == TPG_MODE_RST)
    else $error("mode register not zero after reset");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rstn) mode_r[2] == 1'b0 && mode_r[6] == 1'b0)
    else $error("reserved mode bits set");
  a_bitop_keeps: assert property (@(posedge i_clk) disable iff (!i_rstn)
      hit(TPG_ADDR_BITOP) |=> (mode_r & 8'hf7) == ($past(mode_r) & 8'hf7))
    else $error("single-bit write disturbed other bits");
  a_byte_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      wr_mode |=> mode_r == ($past(i_wdata) & TPG_MODE_WMASK))
    else $error("mode byte write not stored");
  a_reload_block: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !mode_r[TPG_B_RELOAD] |=> latch_r == $past(latch_r))
    else $error("latch changed while reload disabled");
  a_stop_freeze: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !run && !start |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");
  a_start_clear: assert property (@(posedge i_clk) disable iff (!i_rstn) start |=> cnt_r == '0 && tcnt_r == '0)
    else $error("start did not clear counter");
  a_static_pin: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !mode_r[TPG_B_OSEL] |-> o_pulse_output_pin == mode_r[TPG_B_LEVEL])
    else $error("static level not on pin");
  a_pwm_irq: assert property (@(posedge i_clk) disable iff (!i_rstn)
      pwm_period && !hit(TPG_ADDR_STAT) |=> stat_r[TPG_ST_IRQ])
    else $error("periodic flag not set");
  a_square_toggle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      interval_hit && !start |=> tff_r != $past(tff_r))
    else $error("square wave did not toggle");
  a_stat_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
      stat_r[TPG_ST_IRQ] && !hit(TPG_ADDR_STAT) |=> stat_r[TPG_ST_IRQ])
    else $error("status flag lost without clear");

  // Timer path
  a_psc_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !start && !(run && timer_mode && psc_tick) |=> tcnt_r == $past(tcnt_r))
    else $error("interval counter moved without tick");
  a_interval_flag: assert property (@(posedge i_clk) disable iff (!i_rstn)
      interval_hit && !hit(TPG_ADDR_STAT) |=> stat_r[TPG_ST_IRQ])
    else $error("interval flag not set");
  a_interval_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
      interval_hit |=> tcnt_r == '0)
    else $error("interval counter not restarted");
  a_square_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !interval_hit && !start |=> tff_r == $past(tff_r))
    else $error("square wave moved between intervals");
  a_timer_pin: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode_r[TPG_B_OSEL] && timer_mode |-> o_pulse_output_pin == tff_r)
    else $error("square wave not on pin");
  a_tcnt_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !run && !start |=> tcnt_r == $past(tcnt_r))
    else $error("interval counter moved while stopped");

  // PWM path and shared counter/start checks
  a_pwm_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !run || timer_mode |=> pwm_r)
    else $error("idle pwm not high");
  a_pwm_start_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
      run && !timer_mode && base_ph == '0 && low_len != '0 |=> !pwm_r)
    else $error("pwm base period did not start low");
  a_pwm_pin: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode_r[TPG_B_OSEL] && !timer_mode |-> o_pulse_output_pin == pwm_r)
    else $error("pwm not on pin");
  a_reload_copy: assert property (@(posedge i_clk) disable iff (!i_rstn)
      mode_r[TPG_B_RELOAD] |=> latch_r == {$past(modulo_high_reg_r), $past(modulo_low_reg_r[7:TPG_PSC_LO])})
    else $error("latch not reloaded");
  a_run_counts: assert property (@(posedge i_clk) disable iff (!i_rstn)
      run && !start |=> cnt_r == TPG_PWM_W'($past(cnt_r) + 1'b1))
    else $error("counter did not advance while running");
  a_stop_no_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !run |-> ev == '0)
    else $error("event while stopped");
  a_start_square: assert property (@(posedge i_clk) disable iff (!i_rstn)
      start |=> !tff_r)
    else $error("start did not clear square wave");

  // Pin and register port
  a_drive_oe: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_pulse_output_pin_oe == mode_r[TPG_B_DRIVE])
    else $error("pin enable not from drive bit");
  a_oe_reset: assert property (@(posedge i_clk) $rose(i_rstn) |-> !o_pulse_output_pin_oe)
    else $error("pin driven after reset");
  a_stat_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
      hit(TPG_ADDR_STAT) && i_wdata[TPG_ST_IRQ] && !ev[TPG_ST_IRQ] |=> !stat_r[TPG_ST_IRQ])
    else $error("status flag not cleared");
  a_set_wins: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ev[TPG_ST_IRQ] |=> stat_r[TPG_ST_IRQ])
    else $error("event lost against clear");
  a_mask_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      hit(TPG_ADDR_MASK) |=> mask_r == $past(i_wdata[TPG_NEV-1:0]))
    else $error("mask write not stored");
  a_modulo_high_reg_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      hit(TPG_ADDR_MODULO_HIGH_REG) |=> modulo_high_reg_r == $past(i_wdata))
    else $error("modulo high write not stored");
  a_modulo_low_reg_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
      hit(TPG_ADDR_MODULO_LOW_REG) |=> modulo_low_reg_r == $past(i_wdata))
    else $error("modulo low write not stored");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      !i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_mode_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_rd && i_addr == TPG_ADDR_MODE |=> o_rdata == $past(mode_r))
    else $error("mode read wrong");
  a_modulo_low_reg_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_rd && i_addr == TPG_ADDR_MODULO_LOW_REG |=> o_rdata[1:0] == 2'b00)
    else $error("modulo low low bits not zero");

endmodule : tpg_core
`default_nettype wire

// ===== hdl/tpg_pkg.sv
package tpg_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] TPG_ADDR_MODE = 3'h0;
  localparam logic [2:0] TPG_ADDR_MODULO_HIGH_REG = 3'h1;
  localparam logic [2:0] TPG_ADDR_MODULO_LOW_REG = 3'h2;
  localparam logic [2:0] TPG_ADDR_BITOP = 3'h3;
  localparam logic [2:0] TPG_ADDR_STAT = 3'h4;
  localparam logic [2:0] TPG_ADDR_MASK = 3'h5;
  // Mode register fields
  localparam int TPG_B_MODE = 0;
  localparam int TPG_B_RUN = 1;
  localparam int TPG_B_RELOAD = 3;
  localparam int TPG_B_LEVEL = 4;
  localparam int TPG_B_OSEL = 5;
  localparam int TPG_B_DRIVE = 7;
  localparam logic [7:0] TPG_MODE_WMASK = 8'hbb;
  localparam logic [7:0] TPG_MODE_RST = 8'h00;
  localparam logic [7:0] TPG_MODULO_HIGH_REG_RST = 8'hff;
  localparam logic [7:0] TPG_MODULO_LOW_REG_RST = 8'h04;
  // Single-bit op: bit 0 = value for reload enable
  localparam int TPG_BITOP_VAL = 0;
  // Status bits
  localparam int TPG_ST_IRQ = 0;
  localparam int TPG_NEV = 1;
  // Timing
  localparam int TPG_BASE_W = 10;
  localparam int TPG_PWM_W = 15;
  localparam int TPG_LATCH_W = 14;
  localparam int TPG_PSC_W = 8;
  localparam int TPG_PSC_LO = 2;
endpackage : tpg_pkg

// ===== dv/tpg_load.sv
`timescale 1ns/1ps
`default_nettype none
module tpg_load
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic i_oe,
  output logic [15:0] o_low_cnt
);
  // Charge drawn while driven low, like a filter cap; a floating pin draws none
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_low_cnt <= 16'h0000;
    else if (i_oe && !i_pin)
      o_low_cnt <= o_low_cnt + 16'h0001;
  end
endmodule : tpg_load
`default_nettype wire

// ===== dv/timer_pulse_generator_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pulse_generator_control_tb
  import tpg_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_pin, o_oe, o_irq, p;
  logic [15:0] low_cnt, l1;
  logic [7:0] h, h2;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t1, t2;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  tpg_core #(.CLK_HZ(10_000_000)) DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pulse_output_pin(o_pin), .o_pulse_output_pin_oe(o_oe),
    .o_irq(o_irq));
  tpg_load u_load (.i_clk(i_clk), .i_rstn(i_rstn), .i_pin(o_pin), .i_oe(o_oe), .o_low_cnt(low_cnt));
  task summarize;
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rchk(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(n, {8'h00, e}, {8'h00, o_rdata});
  endtask : rchk
  // Bounded wait; time stamp taken at one fixed phase so differences are exact
  task wirq(output int t);
    int n;
    n = 0;
    #1;
    while (o_irq !== 1'b1 && n < 40000)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if (n >= 40000)
      chk("irq wait", 16'h0001, 16'h0000);
    t = cyc;
  endtask : wirq
  // Window starts late enough for a reload to have settled into the waveform
  task meas(input logic [15:0] e);
    repeat (1100) @(posedge i_clk);
    #1 l1 = low_cnt;
    repeat (1024) @(posedge i_clk);
    #1 chk("pwm low", e, low_cnt - l1);
  endtask : meas
  initial
  begin
    void'($urandom(73));
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1 chk("oe rst", 16'h0000, {15'h0, o_oe});
    rchk("mode rst", TPG_ADDR_MODE, TPG_MODE_RST);
    rchk("modulo_high_reg rst", TPG_ADDR_MODULO_HIGH_REG, 8'hff);
    wr(3'h7, 8'h5a);
    rchk("unmapped", 3'h7, 8'h00);
    repeat (8)
    begin
      h = 8'($urandom);
      wr(TPG_ADDR_MODE, h);
      rchk("mode rw", TPG_ADDR_MODE, h & 8'hbb);
    end
    wr(TPG_ADDR_MODE, 8'hb0);
    wr(TPG_ADDR_BITOP, 8'h01);
    rchk("bit set", TPG_ADDR_MODE, 8'hb8);
    wr(TPG_ADDR_BITOP, 8'h00);
    rchk("bit clr", TPG_ADDR_MODE, 8'hb0);
    for (int lv = 0; lv < 2; lv++)
    begin
      wr(TPG_ADDR_MODE, lv[0] ? 8'h90 : 8'h80);
      #1 chk("static pin", 16'(lv), {14'h0, o_oe, o_pin} ^ 16'h0002);
    end
    wr(TPG_ADDR_MODE, 8'h30);
    #1 chk("float oe", 16'h0000, {15'h0, o_oe});
    wr(TPG_ADDR_MODULO_HIGH_REG, 8'h01);
    wr(TPG_ADDR_MODULO_LOW_REG, 8'h40);
    wr(TPG_ADDR_MODE, 8'hbb);
    repeat (100) @(posedge i_clk);
    #1 chk("masked irq", 16'h0000, {15'h0, o_irq});
    rchk("status", TPG_ADDR_STAT, 8'h01);
    wr(TPG_ADDR_MASK, 8'h01);
    #1 chk("unmasked irq", 16'h0001, {15'h0, o_irq});
    wr(TPG_ADDR_MODE, 8'hb9);
    wr(TPG_ADDR_STAT, 8'h01);
    #1 chk("cleared irq", 16'h0000, {15'h0, o_irq});
    for (int k = 0; k < 5; k++)
    begin
      h = 8'(1 + $urandom % 2);
      wr(TPG_ADDR_MODE, 8'h00);
      wr(TPG_ADDR_MODULO_HIGH_REG, h);
      wr(TPG_ADDR_MODULO_LOW_REG, 8'(8'h04 << k));
      wr(TPG_ADDR_STAT, 8'h01);
      wr(TPG_ADDR_MODE, 8'hbb);
      wirq(t1);
      p = o_pin;
      wr(TPG_ADDR_STAT, 8'h01);
      wirq(t2);
      chk("interval", 16'((h + 1) * (256 >> k)), 16'(t2 - t1));
      chk("square", {15'h0, ~p}, {15'h0, o_pin});
    end
    wr(TPG_ADDR_MODE, 8'hb9);
    wr(TPG_ADDR_STAT, 8'h01);
    repeat (1000) @(posedge i_clk);
    #1 chk("stopped irq", 16'h0000, {15'h0, o_irq});
    h = 8'(1 + $urandom % 255);
    h2 = 8'(1 + $urandom % 255);
    wr(TPG_ADDR_MODULO_HIGH_REG, h);
    wr(TPG_ADDR_MODULO_LOW_REG, 8'h00);
    wr(TPG_ADDR_MODE, 8'haa);
    meas(16'(4 * h));
    wr(TPG_ADDR_BITOP, 8'h00);
    wr(TPG_ADDR_MODULO_HIGH_REG, h2);
    meas(16'(4 * h));
    wr(TPG_ADDR_BITOP, 8'h01);
    meas(16'(4 * h2));
    wr(TPG_ADDR_STAT, 8'h01);
    wirq(t1);
    wr(TPG_ADDR_STAT, 8'h01);
    wirq(t2);
    chk("pwm flag", 16'h8000, 16'(t2 - t1));
    summarize();
  end
  initial
  begin
    repeat (98000) @(posedge i_clk);
    err_count++;
    summarize();
  end
endmodule : timer_pulse_generator_control_tb
`default_nettype wire
